// *** common/dpsc_regs.vh ***
// Register map and timing constants of the display power save control block
`ifndef DPSC_REGS_VH
`define DPSC_REGS_VH
`define DPSC_ADDR_W 9
`define DPSC_OFS_CFG 9'h1F0
`define DPSC_OFS_STAT 9'h1F1
`define DPSC_OFS_MODE 9'h1F2
`define DPSC_CFG_SAVE 0
`define DPSC_STAT_PANEL 0
`define DPSC_STAT_MEM 1
`define DPSC_MODE_LCD 0
`define DPSC_MODE_CRT 1
`define DPSC_CFG_RST 8'h00
`define DPSC_MODE_RST 8'h03
`define DPSC_CLK_NS 8
`define DPSC_PANEL_STEP_NS 1000
`define DPSC_PANEL_STEPS (`DPSC_PANEL_STEP_NS / `DPSC_CLK_NS)
`define DPSC_SR_NS 200
`define DPSC_SR_CYC ((`DPSC_SR_NS + `DPSC_CLK_NS - 1) / `DPSC_CLK_NS)
`endif

// *** verilog/dpsc_panel_seq.v ***
// Panel power sequencer: steps the panel down or up and reports when fully off
`include "dpsc_regs.vh"
module dpsc_panel_seq (
  input wire refClk,
  input wire arstN,
  input wire panelOffReq,
  output reg panelDown,
  output wire lcdRun
);
  localparam [3:0] S_DOWN = 4'h1;
  localparam [3:0] S_UP_GO = 4'h2;
  localparam [3:0] S_ON = 4'h4;
  localparam [3:0] S_DN_GO = 4'h8;
  // Step count fits the 8-bit counter; cut to width on purpose
  localparam [31:0] STEPS_W = `DPSC_PANEL_STEPS;
  reg [3:0] state_r;
  reg [7:0] cnt_r;
  wire done = (cnt_r == 8'h00);
  always @(posedge refClk or negedge arstN) begin
    if (!arstN) begin
      state_r <= S_DOWN;
      cnt_r <= 8'h00;
      panelDown <= 1'b1;
    end else begin
      if (!done)
        cnt_r <= cnt_r - 8'h01;
      case (state_r)
        S_DOWN: begin
          if (!panelOffReq) begin
            state_r <= S_UP_GO;
            cnt_r <= STEPS_W[7:0];
            panelDown <= 1'b0;
          end
        end
        S_UP_GO: begin
          if (panelOffReq) begin
            state_r <= S_DN_GO;
            cnt_r <= STEPS_W[7:0];
          end else if (done)
            state_r <= S_ON;
        end
        S_ON: begin
          if (panelOffReq) begin
            state_r <= S_DN_GO;
            cnt_r <= STEPS_W[7:0];
          end
        end
        S_DN_GO: begin
          if (done) begin
            state_r <= S_DOWN;
            panelDown <= 1'b1;
          end
        end
        default: begin
          state_r <= S_DOWN;
          panelDown <= 1'b1;
        end
      endcase
    end
  end
  // Panel data only while fully up, so power steps never see live data
  assign lcdRun = (state_r == S_ON);
endmodule

// *** verilog/dpsc_mem_ctl.v ***
// SDRAM power state: enters self-refresh on request and reports the interface down
`include "dpsc_regs.vh"
module dpsc_mem_ctl (
  input wire refClk,
  input wire arstN,
  input wire saveReq,
  output reg memDown,
  output reg selfRefresh,
  output wire memClkEn
);
  reg [7:0] cnt_r;
  localparam [31:0] SR_CYC_W = `DPSC_SR_CYC;
  always @(posedge refClk or negedge arstN) begin
    if (!arstN) begin
      cnt_r <= 8'h00;
      memDown <= 1'b0;
      selfRefresh <= 1'b0;
    end else if (saveReq) begin
      selfRefresh <= 1'b1;
      if (cnt_r != SR_CYC_W[7:0])
        cnt_r <= cnt_r + 8'h01;
      else
        memDown <= 1'b1;
    end else begin
      // Leaving: report active and exit self-refresh in the same cycle
      memDown <= 1'b0;
      selfRefresh <= 1'b0;
      cnt_r <= 8'h00;
    end
  end
  // Interface clock gated once down
  assign memClkEn = !memDown;
endmodule

// *** verilog/dpsc_top.v ***
// Display power save control: registers, access gating and output shutdown
// Contract
// - Writing 1 to config bit 0 enters power save.
// - Power save disables LCD and CRT/TV outputs.
// - Power save refuses display memory access, keeps register access.
// - Power save keeps SDRAM in self-refresh.
// - Status bit 0 is 1 only when panel fully down.
// - Panel status bit reads 1 after reset.
// - Status bit 1 is 1 when SDRAM interface down in self-refresh.
// - Memory status rises shortly after power save entry.
// - Memory status bit clears to 0 at reset.
// - LCD lookup table stays reachable; needs pixel clock if only LCD off.
// - CRT/TV lookup table stays reachable; needs its clock if only it off.
// - Internal clock networks gated when unneeded.
// - Unused display pipelines shut down per selected mode.
`include "dpsc_regs.vh"
module dpsc_top (
  input wire ref_clk,
  input wire arst_n,
  input wire [8:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  input wire memReq,
  output wire memGrant,
  output wire memRefused,
  input wire lcdLutReq,
  input wire lcdPixClkOk,
  output wire lcdLutGrant,
  input wire crtLutReq,
  input wire crtPixClkOk,
  output wire crtLutGrant,
  input wire [15:0] lcdDataIn,
  output reg [15:0] lcdData,
  output reg lcdEn,
  output reg crtEn,
  output wire lcdPipeClkEn,
  output wire crtPipeClkEn,
  output wire memClkEn,
  output wire sdramSelfRefresh
);
  reg [7:0] cfg_r;
  reg [7:0] mode_r;
  reg lcdOkS1_r;
  reg lcdOk_r;
  reg crtOkS1_r;
  reg crtOk_r;
  wire panelDown;
  wire lcdRun;
  wire memDown;
  wire saveOn = cfg_r[`DPSC_CFG_SAVE];
  wire lcdSel = mode_r[`DPSC_MODE_LCD];
  wire crtSel = mode_r[`DPSC_MODE_CRT];
  wire lcdActive = lcdSel && !saveOn;
  wire crtActive = crtSel && !saveOn;

  function hit;
    input [8:0] a;
    input [8:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Pixel clock presence flags come from another domain
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lcdOkS1_r <= 1'b0;
      lcdOk_r <= 1'b0;
      crtOkS1_r <= 1'b0;
      crtOk_r <= 1'b0;
    end else begin
      lcdOkS1_r <= lcdPixClkOk;
      lcdOk_r <= lcdOkS1_r;
      crtOkS1_r <= crtPixClkOk;
      crtOk_r <= crtOkS1_r;
    end
  end

  // Register file stays live in every mode
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= `DPSC_CFG_RST;
      mode_r <= `DPSC_MODE_RST;
      regRdata <= 8'h00;
    end else begin
      if (regWr && hit(regAddr, `DPSC_OFS_CFG))
        cfg_r <= {7'h00, regWdata[`DPSC_CFG_SAVE]};
      if (regWr && hit(regAddr, `DPSC_OFS_MODE))
        mode_r <= {6'h00, regWdata[1:0]};
      regRdata <= 8'h00;
      if (regRd) begin
        if (hit(regAddr, `DPSC_OFS_CFG))
          regRdata <= cfg_r;
        else if (hit(regAddr, `DPSC_OFS_STAT))
          regRdata <= {6'h00, memDown, panelDown};
        else if (hit(regAddr, `DPSC_OFS_MODE))
          regRdata <= mode_r;
      end
    end
  end

  dpsc_panel_seq uPanel (
    .refClk(ref_clk),
    .arstN(arst_n),
    .panelOffReq(!lcdActive),
    .panelDown(panelDown),
    .lcdRun(lcdRun)
  );

  dpsc_mem_ctl uMem (
    .refClk(ref_clk),
    .arstN(arst_n),
    .saveReq(saveOn),
    .memDown(memDown),
    .selfRefresh(sdramSelfRefresh),
    .memClkEn(memClkEn)
  );

  // Display memory closed from the entry write on, not only once SDRAM is down
  assign memGrant = memReq && !saveOn && !sdramSelfRefresh;
  assign memRefused = memReq && !memGrant;

  // Lookup tables: in power save served on the host clock; with only the
  // display off they sit in the pixel domain and need its clock
  assign lcdLutGrant = lcdLutReq && (saveOn || lcdSel || lcdOk_r);
  assign crtLutGrant = crtLutReq && (saveOn || crtSel || crtOk_r);

  assign lcdPipeClkEn = lcdActive || !panelDown;
  assign crtPipeClkEn = crtActive;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lcdData <= 16'h0000;
      lcdEn <= 1'b0;
      crtEn <= 1'b0;
    end else begin
      lcdEn <= lcdRun;
      lcdData <= lcdRun ? lcdDataIn : 16'h0000;
      crtEn <= crtActive;
    end
  end
endmodule

// *** tb/dpsc_clk_src.sv ***
// Pixel clock source model on the system side
module dpsc_clk_src (
  input logic ref_clk,
  input logic stopReq,
  input logic panelOff,
  input logic memOff,
  output logic lcdPixClkOk = 1'b1,
  output logic crtPixClkOk = 1'b1,
  output logic memClkOn = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stop the panel clock only once the panel reads fully down
  always @(posedge ref_clk) begin
    lcdPixClkOk <= !(stopReq && panelOff);
    crtPixClkOk <= !stopReq;
    // Memory clock stops only once memory status reads down
    memClkOn <= !(stopReq && memOff);
  end
endmodule

// *** tb/dpsc_monitor.sv ***
// Assertion checker for the power save block
module dpsc_monitor (
  input logic ref_clk,
  input logic arst_n,
  input logic [8:0] regAddr,
  input logic [7:0] regWdata,
  input logic regWr,
  input logic regRd,
  input logic [7:0] regRdata,
  input logic memReq,
  input logic memGrant,
  input logic memRefused,
  input logic lcdLutReq,
  input logic lcdLutGrant,
  input logic lcdEn,
  input logic crtEn,
  input logic memClkEn,
  input logic sdramSelfRefresh
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire cfgWr = regWr && regAddr == 9'h1F0;
  sequence memFall;
    memClkEn [*8] ##[1:40] !memClkEn;
  endsequence
  a_save_on: assert property (cfgWr && regWdata[0] |-> ##2 sdramSelfRefresh)
    else $error("save entry missed");
  a_save_off: assert property (cfgWr && !regWdata[0] |-> ##2 !sdramSelfRefresh)
    else $error("save exit missed");
  a_mem_refuse: assert property (memReq && sdramSelfRefresh |-> memRefused && !memGrant)
    else $error("memory not refused");
  a_out_off: assert property (sdramSelfRefresh [*3] |-> !lcdEn && !crtEn)
    else $error("display still on");
  a_mem_down: assert property ($rose(sdramSelfRefresh) |-> memFall)
    else $error("memory down timing");
  a_mem_stat: assert property (regRd && regAddr == 9'h1F1 |=> regRdata[1] == !$past(memClkEn))
    else $error("memory status wrong");
  a_lut_keep: assert property (lcdLutReq && sdramSelfRefresh |-> lcdLutGrant)
    else $error("lookup table blocked");
  a_reg_void: assert property (regRd && regAddr == 9'h100 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind dpsc_top dpsc_monitor mon (.ref_clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd,
  .regRdata, .memReq, .memGrant, .memRefused, .lcdLutReq, .lcdLutGrant, .lcdEn, .crtEn,
  .memClkEn, .sdramSelfRefresh);

// *** tb/dpsc_tb_top.sv ***
// Testbench for the power save block
module dpsc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, arst_n = 0, regWr = 0, regRd = 0, memReq = 0, lcdLutReq = 0;
  logic crtLutReq = 0, stopReq = 0, panelOff = 0, lcdPixClkOk, crtPixClkOk, memGrant;
  logic memOff = 0, memClkOn;
  logic memRefused, lcdLutGrant, crtLutGrant, lcdEn, crtEn, lcdPipeClkEn, crtPipeClkEn;
  logic memClkEn, sdramSelfRefresh;
  logic [8:0] regAddr = 9'h000;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [15:0] lcdDataIn = 16'hA5C3, lcdData;
  int bad_count = 0, checked = 0;
  always #4 ref_clk = ~ref_clk;
  dpsc_top dut (.ref_clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .memReq,
    .memGrant, .memRefused, .lcdLutReq, .lcdPixClkOk, .lcdLutGrant, .crtLutReq, .crtPixClkOk,
    .crtLutGrant, .lcdDataIn, .lcdData, .lcdEn, .crtEn, .lcdPipeClkEn, .crtPipeClkEn,
    .memClkEn, .sdramSelfRefresh);
  dpsc_clk_src clks (.ref_clk, .stopReq, .panelOff, .memOff, .lcdPixClkOk, .crtPixClkOk,
    .memClkOn);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1;
    @(posedge ref_clk);
    regWr <= 0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1;
    @(posedge ref_clk);
    regRd <= 0;
    #1 chk(regRdata, e);
  endtask
  task automatic tIdle;
    // Read strobe stands at the first edge out of reset
    regAddr <= 9'h1F1;
    regRd <= 1;
    @(posedge ref_clk);
    regRd <= 0;
    #1 chk(regRdata, 8'h01);
    wt(200);
    rd(9'h1F1, 8'h00);
    rd(9'h1F2, 8'h03);
    rd(9'h100, 8'h00);
  endtask
  task automatic tSave;
    memReq <= 1;
    lcdLutReq <= 1;
    crtLutReq <= 1;
    wr(9'h1F0, 8'h01);
    #1 chk(memRefused, 1);
    wt(30);
    rd(9'h1F1, 8'h02);
    wt(130);
    rd(9'h1F1, 8'h03);
    rd(9'h1F0, 8'h01);
    chk({lcdData, lcdEn, crtEn}, 0);
    panelOff <= 1;
    memOff <= 1;
    stopReq <= 1;
    wt(4);
    #1 chk({lcdLutGrant, crtLutGrant, memClkOn}, 6);
  endtask
  task automatic tExit;
    stopReq <= 0;
    panelOff <= 0;
    memOff <= 0;
    wr(9'h1F0, 8'h00);
    wt(2);
    rd(9'h1F1, 8'h00);
    chk({memGrant, memClkOn}, 3);
    wt(140);
    #1 chk({lcdData, lcdEn, crtEn}, {lcdDataIn, 2'b11});
  endtask
  task automatic tMode;
    wr(9'h1F2, 8'h02);
    wt(140);
    rd(9'h1F1, 8'h01);
    chk({lcdPipeClkEn, crtPipeClkEn}, 1);
    panelOff <= 1;
    stopReq <= 1;
    wt(4);
    #1 chk(lcdLutGrant, 0);
    stopReq <= 0;
    wt(4);
    #1 chk(lcdLutGrant, 1);
    // Panel powers up again, so its clock must keep running
    panelOff <= 0;
    wr(9'h1F2, 8'h01);
    stopReq <= 1;
    wt(4);
    #1 chk({crtLutGrant, crtPipeClkEn, lcdLutGrant}, 1);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run is near 700 cycles; allow far more
  initial begin
    #200000;
    bad_count++;
    conclude;
  end
  initial begin
    wt(2);
    arst_n <= 1;
    tIdle;
    tSave;
    tExit;
    tMode;
    conclude;
  end
endmodule
